// File: src/ctrl_action_cfg.svh
// ctrl_action_cfg.svh: constants for the control input action decoder
// assumes a 250 MHz system clock; included by bare name
`ifndef CTRL_ACTION_CFG_SVH
`define CTRL_ACTION_CFG_SVH

`define CLK_HZ            250000000
`define CYC_PER_SEC       (`CLK_HZ)
`define WIDTH_5_S         5
`define WIDTH_10_S        10
`define WIDTH_15_S        15
`define SEC_CNT_W         28
`define WIDTH_SEL_RESET   2'h0
`define FUNC_RESET        3'h3
`define OVR_RESET         2'h0

`endif

// File: src/ctrl_action_pkg.sv
// ctrl_action_pkg.sv: types shared by the control input action decoder
// assumes nothing beyond a SystemVerilog compiler
package ctrl_action_pkg;

    // function selection for the control input
    typedef enum logic [2:0]
    {
        FUNC_CAL          = 3'h0,
        FUNC_TEST_ZERO    = 3'h1,
        FUNC_TEST         = 3'h2,
        FUNC_HOLD_CAL_PZ  = 3'h3,
        FUNC_HOLD_CAL_PT  = 3'h4
    } func_sel_t;

    // maximum pulse width choice
    typedef enum logic [1:0]
    {
        WIDTH_5   = 2'h0,
        WIDTH_10  = 2'h1,
        WIDTH_15  = 2'h2
    } width_sel_t;

    // calibration override
    typedef enum logic [1:0]
    {
        OVR_FOLLOW = 2'h0,
        OVR_ON     = 2'h1,
        OVR_OFF    = 2'h2
    } cal_ovr_t;

    // action start pulses
    typedef struct packed
    {
        logic cal;        // start calibration
        logic test;       // start self-test
        logic zero;       // auto-zero after self-test
    } action_t;

endpackage : ctrl_action_pkg

// File: src/second_tick.sv
// second_tick.sv: free-running divider giving a one-cycle pulse each second
// assumes a single clock and async active-low reset
`timescale 1ns/1ps

module second_tick
    import ctrl_action_pkg::*;
#(
    parameter int unsigned CYCLES = 250000000  // cycles per tick
)
(
    input  wire logic clk,      // system clock
    input  wire logic arst_n,   // async reset, active low
    input  wire logic clear,    // restart the count
    output logic      tick      // one-cycle pulse
);

    localparam int W = $clog2(CYCLES);

    logic [W-1:0] count;        // cycle counter

    // count cycles, pulse at the end of each period
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            count <= '0;
            tick  <= 1'b0;
        end
        else if (clear)
        begin
            count <= '0;
            tick  <= 1'b0;
        end
        else if (count == W'(CYCLES - 1))
        begin
            count <= '0;
            tick  <= 1'b1;
        end
        else
        begin
            count <= count + 1'b1;
            tick  <= 1'b0;
        end
    end

endmodule : second_tick

// File: src/ctrl_action_decoder.sv
// ctrl_action_decoder.sv: turns the external control input into actions
// assumes settings come from firmware on the same clock; ctrl_in is async
//
// Operation
// - calibration-only mode: calibrate on rising edge
// - self-test plus auto-zero mode: on high
// - self-test-only mode: self-test on high
// - hold calibrates, pulse gives self-test plus zero
// - hold-cal/pulse-test-zero is the default function
// - hold calibrates, pulse gives self-test only
// - maximum width 5, 10 or 15 s
// - shorter than maximum is pulse, else hold
// - override on: calibration always enabled
// - override off: calibration always disabled
// - override returns to follow on reset
// - calibration on drives status output low
`timescale 1ns/1ps
`include "ctrl_action_cfg.svh"

module ctrl_action_decoder
    import ctrl_action_pkg::*;
#(
    parameter int unsigned CYC_PER_SEC = `CYC_PER_SEC  // shorten in simulation
)
(
    input  wire logic       clk,        // 250 MHz system clock
    input  wire logic       arst_n,     // async reset, active low
    input  wire logic       ctrl_in,    // external control pin, async
    input  wire logic       func_wr,    // strobe: load function selection
    input  wire func_sel_t  func_in,    // new function selection
    input  wire logic       width_wr,   // strobe: load pulse width choice
    input  wire width_sel_t width_in,   // new pulse width choice
    input  wire logic       ovr_wr,     // strobe: load calibration override
    input  wire cal_ovr_t   ovr_in,     // new override value
    output action_t         action,     // one-cycle action start pulses
    output logic            cal_enabled,// calibration currently enabled
    output logic            status_ok,  // status output, low while cal on
    output func_sel_t       func_now,   // function in effect
    output width_sel_t      width_now   // pulse width in effect
);

    ////////////////////////////////////////////////////////////////////
    // settings

    cal_ovr_t ovr;              // calibration override

    // function selection, default is hold-cal / pulse test+zero
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            func_now <= func_sel_t'(`FUNC_RESET);
        else if (func_wr && func_in <= FUNC_HOLD_CAL_PT)
            func_now <= func_in;
    end

    // width choice, default 5 s; reserved code ignored
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            width_now <= width_sel_t'(`WIDTH_SEL_RESET);
        else if (width_wr && width_in != 2'h3)
            width_now <= width_in;
    end

    // override, back to follow on every reset
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            ovr <= cal_ovr_t'(`OVR_RESET);
        else if (ovr_wr && ovr_in != 2'h3)
            ovr <= ovr_in;
    end

    ////////////////////////////////////////////////////////////////////
    // input synchroniser

    logic [2:0] sync;           // three-stage synchroniser
    logic       level;          // filtered input level

    // shift pin through three flops
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            sync <= 3'h0;
        else
            sync <= {sync[1:0], ctrl_in};
    end

    // accept a change once stages two and three agree
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            level <= 1'b0;
        else if (sync[1] == sync[2])
            level <= sync[2];
    end

    logic level_d;              // previous level
    logic rise;                 // rising edge of level
    logic fall;                 // falling edge of level

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            level_d <= 1'b0;
        else
            level_d <= level;
    end

    assign rise = level & ~level_d;
    assign fall = ~level & level_d;

    ////////////////////////////////////////////////////////////////////
    // seconds timing of the high interval

    logic       sec;            // one-second tick while high
    logic [3:0] secs;           // whole seconds counted
    logic [3:0] limit;          // selected maximum in seconds
    logic       decided;        // action already chosen for this high

    second_tick #(
        .CYCLES (CYC_PER_SEC)
    ) u_tick (
        .clk    (clk),
        .arst_n (arst_n),
        .clear  (~level),
        .tick   (sec)
    );

    // map width choice to seconds
    always_comb
    begin
        unique case (width_now)
            WIDTH_10: limit = 4'(`WIDTH_10_S);
            WIDTH_15: limit = 4'(`WIDTH_15_S);
            default:  limit = 4'(`WIDTH_5_S);
        endcase
    end

    // count seconds high, cleared while low
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            secs <= 4'h0;
        else if (!level)
            secs <= 4'h0;
        else if (sec && secs < limit)                // stop at the maximum
            secs <= secs + 4'h1;
    end

    logic combined;             // hold/pulse function in effect
    logic hold_hit;             // high time just reached the maximum

    assign combined = (func_now == FUNC_HOLD_CAL_PZ) || (func_now == FUNC_HOLD_CAL_PT);
    // maximum reached while high, or on the very edge it falls: still a hold
    assign hold_hit = (level || fall) && !decided && secs >= limit;

    // one decision per high interval
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            decided <= 1'b0;
        else if (!level)
            decided <= 1'b0;
        else if (hold_hit)
            decided <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////
    // calibration enable and status

    // override forces on or off, else follow function selection
    always_comb
    begin
        unique case (ovr)
            OVR_ON:  cal_enabled = 1'b1;
            OVR_OFF: cal_enabled = 1'b0;
            default: cal_enabled = (func_now == FUNC_CAL) || combined;
        endcase
    end

    // status low while calibration is enabled and override is on, a cal pulse starts or the pin is high
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            status_ok <= 1'b1;
        else
            status_ok <= ~(cal_enabled && (ovr == OVR_ON || action.cal || level));
    end

    ////////////////////////////////////////////////////////////////////
    // action decode

    action_t next_action;       // combinational action choice

    always_comb
    begin
        next_action = '0;
        unique case (func_now)
            FUNC_CAL:
                next_action.cal = rise && cal_enabled;
            FUNC_TEST_ZERO:
            begin
                next_action.test = rise;
                next_action.zero = rise;
            end
            FUNC_TEST:
                next_action.test = rise;
            FUNC_HOLD_CAL_PZ, FUNC_HOLD_CAL_PT:
            begin
                // hold: reached the maximum first
                next_action.cal  = hold_hit && cal_enabled;
                // pulse: fell strictly before the maximum
                next_action.test = fall && !decided && secs < limit;
                next_action.zero = next_action.test && func_now == FUNC_HOLD_CAL_PZ;
            end
            default:
                next_action = '0;
        endcase
    end

    // register action pulses
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            action <= '0;
        else
            action <= next_action;
    end

endmodule : ctrl_action_decoder

// File: verification/ctrl_action_checker_asserts.sv
// ctrl_action_checker_asserts.sv: assertions on the decoder's ports
// assumes one clock domain; bound to every decoder instance
`timescale 1ns/1ps

module ctrl_action_checker
    import ctrl_action_pkg::*;
#(
    parameter int unsigned CYC_PER_SEC = 10  // cycles per second
)
(
    input wire logic       clk,         // system clock
    input wire logic       arst_n,      // async reset, active low
    input wire logic       ctrl_in,     // control pin
    input wire logic       ovr_wr,      // override strobe
    input wire cal_ovr_t   ovr_in,      // override value
    input wire action_t    action,      // action pulses
    input wire logic       cal_enabled, // calibration enabled
    input wire logic       status_ok,   // status output
    input wire func_sel_t  func_now,    // function in effect
    input wire width_sel_t width_now    // width in effect
);
    int unsigned lim;    // limit in cycles
    int unsigned hi_cnt; // cycles the pin has stayed high
    always_comb lim = CYC_PER_SEC * (width_now == WIDTH_5 ? 5 : width_now == WIDTH_10 ? 10 : 15);
    // high time of the raw pin, cleared when it drops
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            hi_cnt <= 0;
        else
            hi_cnt <= ctrl_in ? hi_cnt + 1 : 0;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    cal_mode_a:
        assert property (func_now == FUNC_CAL && cal_enabled && $rose(ctrl_in) |-> ##[3:8] action.cal)
        else $error("no cal on rise");
    test_zero_a:
        assert property (func_now == FUNC_TEST_ZERO && $rose(ctrl_in) |-> ##[3:8] action == 3'b011)
        else $error("no test and zero on rise");
    test_only_a:
        assert property (func_now == FUNC_TEST && $rose(ctrl_in) |-> ##[3:8] action == 3'b010)
        else $error("no test on rise");
    reset_dflt_a:
        assert property ($rose(arst_n) |-> func_now == FUNC_HOLD_CAL_PZ && width_now == WIDTH_5
            && cal_enabled && status_ok) else $error("bad reset state");
    pulse_zero_a:
        assert property ($fell(ctrl_in) && func_now == FUNC_HOLD_CAL_PZ && hi_cnt + CYC_PER_SEC + 4
            < lim |-> ##[3:8] action == 3'b011) else $error("short pulse not test and zero");
    pulse_test_a:
        assert property ($fell(ctrl_in) && func_now == FUNC_HOLD_CAL_PT && hi_cnt + CYC_PER_SEC + 4
            < lim |-> ##[3:8] action == 3'b010) else $error("short pulse not test");
    hold_cal_a:
        assert property ((func_now == FUNC_HOLD_CAL_PZ || func_now == FUNC_HOLD_CAL_PT)
            && cal_enabled && ctrl_in && hi_cnt == lim + 2 |-> ##[3:8] action.cal)
        else $error("long hold gave no cal");
    cal_block_a:
        assert property (!cal_enabled |-> !action.cal) else $error("cal while disabled");
    ovr_on_a:
        assert property (ovr_wr && ovr_in == OVR_ON |=> cal_enabled ##[0:2] !status_ok)
        else $error("override on ignored");
    status_low_a:
        assert property (action.cal |-> ##[0:1] !status_ok) else $error("status high in cal");
    single_act_a:
        assert property ($rose(action != 3'b000) |=> action == 3'b000 [*8])
        else $error("repeated action");
    cover property (action.cal);
    cover property (action == 3'b011);
    cover property (!cal_enabled && $rose(ctrl_in));
endmodule : ctrl_action_checker

bind ctrl_action_decoder ctrl_action_checker #(.CYC_PER_SEC(CYC_PER_SEC)) chk (.clk, .arst_n,
    .ctrl_in, .ovr_wr, .ovr_in, .action, .cal_enabled, .status_ok, .func_now, .width_now);

// File: verification/ctrl_driver.sv
// ctrl_driver.sv: external equipment driving the control pin
// assumes the bench calls press from its own clock domain
`timescale 1ns/1ps

module ctrl_driver
(
    input  wire logic clk,     // system clock
    output logic      ctrl_in  // control pin level
);
    initial ctrl_in = 1'b0; // driven low between presses
    // pin high for n cycles; n comes from the caller and is not checked against the limit
    task automatic press(input int n);
        @(posedge clk) ctrl_in <= 1'b1;
        repeat (n) @(posedge clk);
        ctrl_in <= 1'b0;
    endtask : press
endmodule : ctrl_driver

// File: verification/ctrl_action_decoder_tb.sv
// ctrl_action_decoder_tb.sv: directed bench for the control input decoder
// assumes ctrl_driver on the pin and a second shortened to 10 cycles
`timescale 1ns/1ps

module ctrl_action_decoder_tb;
    import ctrl_action_pkg::*;
    localparam int unsigned CPS = 10; // cycles per simulated second
    logic       clk, arst_n, ctrl_in, func_wr, width_wr, ovr_wr;
    func_sel_t  func_in, func_now;
    width_sel_t width_in, width_now;
    cal_ovr_t   ovr_in;
    action_t    action;
    logic       cal_enabled, status_ok;
    int         errors = 0, total_checks = 0, cycles = 0;

    ctrl_action_decoder #(.CYC_PER_SEC(CPS)) dut (.clk, .arst_n, .ctrl_in, .func_wr, .func_in,
        .width_wr, .width_in, .ovr_wr, .ovr_in, .action, .cal_enabled, .status_ok,
        .func_now, .width_now);
    ctrl_driver drv (.clk, .ctrl_in);

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            errors++;
            final_report();
        end
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        if (got !== exp)
            errors++;
    endtask : check
    // load all three settings in one cycle
    task automatic set(input func_sel_t f, input width_sel_t w, input cal_ovr_t o);
        @(posedge clk);
        {func_wr, width_wr, ovr_wr} <= 3'h7;
        func_in  <= f;
        width_in <= w;
        ovr_in   <= o;
        @(posedge clk);
        {func_wr, width_wr, ovr_wr} <= 3'h0;
    endtask : set
    // press n cycles, expect exactly one action of kind exp (or none)
    task automatic try(input func_sel_t f, input width_sel_t w, input cal_ovr_t o,
                       input int n, input logic [2:0] exp);
        logic [2:0] seen;
        int         hits;
        seen = 3'h0;
        hits = 0;
        set(f, w, o);
        fork
            drv.press(n);
            repeat (n + 70)
            begin
                @(posedge clk);
                #1;
                if (action !== 3'h0)
                begin
                    seen = action;
                    hits++;
                end
            end
        join
        check({hits[4:0], seen}, {4'h0, exp != 3'h0, exp});
    endtask : try
    task automatic t_reset_state;
        @(posedge clk);
        #1;
        check({1'b0, func_now, width_now, cal_enabled, status_ok},
              {1'b0, FUNC_HOLD_CAL_PZ, WIDTH_5, 2'b11});
    endtask : t_reset_state
    task automatic t_single_modes;
        try(FUNC_CAL, WIDTH_5, OVR_FOLLOW, 3, 3'h4);
        try(FUNC_TEST_ZERO, WIDTH_5, OVR_FOLLOW, 3, 3'h3);
        try(FUNC_TEST, WIDTH_5, OVR_FOLLOW, 3, 3'h2);
    endtask : t_single_modes
    task automatic t_combined;
        try(FUNC_HOLD_CAL_PZ, WIDTH_5, OVR_FOLLOW, 20, 3'h3);
        try(FUNC_HOLD_CAL_PZ, WIDTH_5, OVR_FOLLOW, 60, 3'h4);
        try(FUNC_HOLD_CAL_PT, WIDTH_5, OVR_FOLLOW, 20, 3'h2);
        try(FUNC_HOLD_CAL_PT, WIDTH_5, OVR_FOLLOW, 60, 3'h4);
        try(FUNC_HOLD_CAL_PT, WIDTH_5, OVR_FOLLOW, 52, 3'h4);
    endtask : t_combined
    task automatic t_widths;
        try(FUNC_HOLD_CAL_PZ, WIDTH_10, OVR_FOLLOW, 80, 3'h3);
        try(FUNC_HOLD_CAL_PZ, WIDTH_15, OVR_FOLLOW, 160, 3'h4);
    endtask : t_widths
    task automatic t_override;
        try(FUNC_CAL, WIDTH_5, OVR_OFF, 3, 3'h0);
        try(FUNC_HOLD_CAL_PT, WIDTH_5, OVR_ON, 60, 3'h4);
        set(FUNC_TEST, WIDTH_5, OVR_ON);
        repeat (3) @(posedge clk);
        #1;
        check({6'h0, cal_enabled, status_ok}, 8'h02);
    endtask : t_override
    // illegal codes leave the settings alone; follow mode in self-test blocks cal
    task automatic t_refused;
        set(FUNC_TEST, WIDTH_10, OVR_FOLLOW);
        set(func_sel_t'(3'h7), width_sel_t'(2'h3), cal_ovr_t'(2'h3));
        repeat (2) @(posedge clk);
        #1;
        check({1'b0, func_now, width_now, cal_enabled, status_ok},
              {1'b0, FUNC_TEST, WIDTH_10, 2'b01});
    endtask : t_refused
    task automatic t_reset_mid;
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        t_reset_state();
    endtask : t_reset_mid
    task automatic final_report;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report

    initial
    begin
        arst_n   = 1'b0;
        {func_wr, width_wr, ovr_wr} = 3'h0;
        func_in  = FUNC_CAL;
        width_in = WIDTH_5;
        ovr_in   = OVR_FOLLOW;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        t_reset_state();
        t_single_modes();
        t_combined();
        t_widths();
        t_override();
        t_refused();
        t_reset_mid();
        final_report();
    end
endmodule : ctrl_action_decoder_tb
